/* File: fpes_pkg.sv */
// Purpose: Shared constants and types for the flash program/erase sequencer
// Assumes: 16-bit flash data bus, APB register access at 20 MHz
// Notes: Command codes are the flash bus command bytes
package fpes_pkg;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_ARRAY = 8'hff;
   localparam logic [7:0] CMD_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_BUF_PROG = 8'he9;
   localparam logic [7:0] CMD_FACT_SETUP = 8'h80;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
   localparam logic [15:0] FACT_EXIT_DATA = 16'hffff;
   localparam int BUF_WORDS = 512;
   localparam int COUNT_W = 9;
   // Status bit positions
   localparam int SB_READY = 7;
   localparam int SB_ERASE_ERR = 5;
   localparam int SB_PROG_ERR = 4;
   localparam int SB_VOLT_ERR = 3;
   localparam int SB_SUSP = 2;
   localparam int SB_LOCK_ERR = 1;
   localparam int SB_BUF_READY = 0;
   // APB byte addresses
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_READ = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_CTRL = 8'h0c;
   localparam logic [7:0] A_STATE = 8'h10;
   // Operation timing in microseconds, converted at 20 MHz
   localparam int CLK_MHZ = 20;
   localparam int PROG_US = 2;
   localparam int ERASE_US = 900000;
   localparam int SUSP_US = 20;
   localparam int PROG_CYC = PROG_US * CLK_MHZ;
   localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
   localparam int SUSP_CYC = SUSP_US * CLK_MHZ;
   typedef enum logic [3:0] {
      FPES_IDLE = 4'h0,
      FPES_BP_COUNT = 4'h1,
      FPES_BP_LOAD = 4'h2,
      FPES_BP_CONFIRM = 4'h3,
      FPES_FP_CONFIRM = 4'h4,
      FPES_FP_STREAM = 4'h5,
      FPES_ER_CONFIRM = 4'h6,
      FPES_BUSY = 4'h7,
      FPES_SUSPENDING = 4'h8,
      FPES_SUSPENDED = 4'h9
   } fpes_state_t;
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] data;
   } fpes_wr_t;
endpackage : fpes_pkg

/* File: fpes_timer.sv */
// Purpose: Down-counter that times one internal flash operation
// Assumes: load is a single-cycle pulse and hold a level held by the sequencer
// Notes: done pulses once when the count expires
`timescale 1ns/1ps
`default_nettype none
module fpes_timer #(
   parameter int W = 25
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [W-1:0] cycles,
   input wire logic hold,
   output logic running,
   output logic done
);
   logic [W-1:0] cnt_reg, cnt_next;
   logic done_reg, done_next;
   initial begin
      if (W < 2) $error("fpes_timer width too small");
   end
   always_comb begin
      cnt_next = cnt_reg;
      done_next = 1'b0;
      if (load) begin
         cnt_next = cycles;
      end else if (cnt_reg != '0 && !hold) begin
         cnt_next = cnt_reg - 1'b1;
         done_next = (cnt_reg == {{(W-1){1'b0}}, 1'b1});
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end
   assign running = (cnt_reg != '0);
   assign done = done_reg;
endmodule : fpes_timer
`default_nettype wire

/* File: fpes_seq.sv */
// Purpose: Flash program/erase command sequencer behind an APB port
// Assumes: Software plays the flash bus through CMD writes; one partition modelled
// Notes: Array reads are modelled by a read-back of the addressed word's address
// Functional notes
// [R1] Host suspends with B0h then 70h
// [R2] Ready and suspended bits track suspend
// [R3] Array reads allowed outside suspended block
// [R4] Confirm at suspended block resumes programming
// [R5] Host returns partition to status mode
// [R6] Buffered program: setup then count write
// [R7] Count write low nine bits = words minus one
// [R8] Host loads one word per write, max 512
// [R9] Load outside setup block aborts sequence
// [R10] Bad confirm block or data aborts
// [R11] Confirm switches reads to status
// [R12] Host unlocks, then factory setup and confirm
// [R13] Factory setup flags voltage or lock errors
// [R14] Buffer-ready bit shows factory buffer acceptance
// [R15] Host polls after 512 factory words
// [R16] Buffer-ready held busy while buffer programs
// [R17] All-ones outside block exits factory mode
// [R18] Ready low until factory exit completes
// [R19] Host erases with 20h then D0h
// [R20] Invalid erase sequence sets both errors
// [R21] Locked, failed, voltage faults set errors
// [R22] Only clear-status clears error bits
// [R23] Status mode persists until read-array
`timescale 1ns/1ps
`default_nettype none
module fpes_seq #(
   parameter int BLOCK_LSB = 17,
   parameter int ERASE_CYCLES = fpes_pkg::ERASE_CYC,
   parameter int PROG_CYCLES = fpes_pkg::PROG_CYC,
   parameter int SUSP_CYCLES = fpes_pkg::SUSP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic high_programming_voltage,
   input wire logic block_locked,
   input wire logic op_fail
);
   localparam int TW = 25;
   initial begin
      if (BLOCK_LSB < 1 || BLOCK_LSB > 23) $error("BLOCK_LSB out of range");
      if (ERASE_CYCLES >= (1 << TW) || ERASE_CYCLES < 1) $error("ERASE_CYCLES out of range");
      if (PROG_CYCLES < 1 || SUSP_CYCLES < 1 || SUSP_CYCLES > 65535) $error("bad cycle count");
   end

   fpes_pkg::fpes_state_t st_reg, st_next;
   logic [7:0] sr_reg, sr_next;
   logic stat_mode_reg, stat_mode_next;
   logic [23:0] blk_reg, blk_next;
   logic [8:0] cnt_reg, cnt_next;
   logic [9:0] fcnt_reg, fcnt_next;
   logic is_erase_reg, is_erase_next;
   logic exiting_reg, exiting_next;
   logic [23:0] rd_addr_reg, rd_addr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic t_load, t_hold, t_run, t_done;
   logic [TW-1:0] t_cycles;

   fpes_pkg::fpes_wr_t wr;
   logic acc, cmd_wr;
   logic [7:0] code;
   logic same_blk;

   assign acc = psel && penable;
   assign pready = 1'b1;
   assign cmd_wr = acc && pwrite && (paddr == fpes_pkg::A_CMD);
   assign wr = {pwdata[31:16], 8'h00, pwdata[15:0]};
   assign code = wr.data[7:0];
   assign same_blk = (wr.addr >> BLOCK_LSB) == (blk_reg >> BLOCK_LSB);

   fpes_timer #(.W(TW)) u_timer (
      .clk(clk),
      .rst(rst),
      .load(t_load),
      .cycles(t_cycles),
      .hold(t_hold),
      .running(t_run),
      .done(t_done)
   );

   always_comb begin
      st_next = st_reg;
      sr_next = sr_reg;
      stat_mode_next = stat_mode_reg;
      blk_next = blk_reg;
      cnt_next = cnt_reg;
      fcnt_next = fcnt_reg;
      is_erase_next = is_erase_reg;
      exiting_next = exiting_reg;
      t_load = 1'b0;
      t_hold = (st_reg == fpes_pkg::FPES_SUSPENDED);
      t_cycles = '0;
      if (t_done) begin
         if (st_reg == fpes_pkg::FPES_FP_STREAM) begin
            sr_next[fpes_pkg::SB_BUF_READY] = 1'b0; // [R16]
            if (exiting_reg) begin
               exiting_next = 1'b0;
               st_next = fpes_pkg::FPES_IDLE;
               sr_next[fpes_pkg::SB_READY] = 1'b1; // [R18]
            end
         end else if (st_reg == fpes_pkg::FPES_BUSY) begin
            if (op_fail) begin
               sr_next[is_erase_reg ? fpes_pkg::SB_ERASE_ERR : fpes_pkg::SB_PROG_ERR] = 1'b1; // [R21]
            end
            sr_next[fpes_pkg::SB_READY] = 1'b1;
            st_next = fpes_pkg::FPES_IDLE;
         end
      end
      if (cmd_wr) begin
         if (code == fpes_pkg::CMD_CLR_STATUS && st_reg == fpes_pkg::FPES_IDLE) begin
            sr_next[fpes_pkg::SB_ERASE_ERR] = 1'b0; // [R22]
            sr_next[fpes_pkg::SB_PROG_ERR] = 1'b0; // [R22]
            sr_next[fpes_pkg::SB_VOLT_ERR] = 1'b0; // [R22]
            sr_next[fpes_pkg::SB_LOCK_ERR] = 1'b0; // [R22]
         end else if (code == fpes_pkg::CMD_STATUS && !(st_reg inside
                      {[fpes_pkg::FPES_BP_COUNT:fpes_pkg::FPES_ER_CONFIRM]})) begin
            stat_mode_next = 1'b1; // [R23]
         end else if (code == fpes_pkg::CMD_ARRAY && (st_reg == fpes_pkg::FPES_IDLE
                      || st_reg == fpes_pkg::FPES_SUSPENDED)) begin
            stat_mode_next = 1'b0; // [R3] [R23]
         end else begin
            case (st_reg)
               fpes_pkg::FPES_IDLE: begin
                  blk_next = wr.addr;
                  if (code == fpes_pkg::CMD_BUF_PROG) begin
                     st_next = fpes_pkg::FPES_BP_COUNT; // [R6]
                  end else if (code == fpes_pkg::CMD_FACT_SETUP) begin
                     st_next = fpes_pkg::FPES_FP_CONFIRM;
                  end else if (code == fpes_pkg::CMD_ERASE) begin
                     st_next = fpes_pkg::FPES_ER_CONFIRM;
                  end
               end
               fpes_pkg::FPES_BP_COUNT: begin
                  cnt_next = wr.data[fpes_pkg::COUNT_W-1:0]; // [R7]
                  st_next = same_blk ? fpes_pkg::FPES_BP_LOAD : fpes_pkg::FPES_IDLE;
                  if (!same_blk) sr_next[fpes_pkg::SB_PROG_ERR] = 1'b1;
               end
               fpes_pkg::FPES_BP_LOAD: begin
                  if (!same_blk) begin
                     st_next = fpes_pkg::FPES_IDLE; // [R9]
                     sr_next[fpes_pkg::SB_PROG_ERR] = 1'b1; // [R9]
                  end else if (cnt_reg == '0) begin
                     st_next = fpes_pkg::FPES_BP_CONFIRM;
                  end else begin
                     cnt_next = cnt_reg - 1'b1;
                  end
               end
               fpes_pkg::FPES_BP_CONFIRM: begin
                  stat_mode_next = 1'b1; // [R11]
                  if (!same_blk || code != fpes_pkg::CMD_CONFIRM) begin
                     st_next = fpes_pkg::FPES_IDLE; // [R10]
                     sr_next[fpes_pkg::SB_PROG_ERR] = 1'b1; // [R10]
                  end else if (!high_programming_voltage) begin
                     st_next = fpes_pkg::FPES_IDLE;
                     sr_next[fpes_pkg::SB_VOLT_ERR] = 1'b1;
                  end else if (block_locked) begin
                     st_next = fpes_pkg::FPES_IDLE;
                     sr_next[fpes_pkg::SB_LOCK_ERR] = 1'b1;
                  end else begin
                     st_next = fpes_pkg::FPES_BUSY;
                     is_erase_next = 1'b0;
                     sr_next[fpes_pkg::SB_READY] = 1'b0;
                     t_load = 1'b1;
                     t_cycles = TW'(PROG_CYCLES);
                  end
               end
               fpes_pkg::FPES_FP_CONFIRM: begin
                  stat_mode_next = 1'b1;
                  if (code != fpes_pkg::CMD_CONFIRM || !same_blk) begin
                     st_next = fpes_pkg::FPES_IDLE;
                     sr_next[fpes_pkg::SB_PROG_ERR] = 1'b1;
                  end else if (!high_programming_voltage || block_locked) begin
                     st_next = fpes_pkg::FPES_IDLE;
                     sr_next[fpes_pkg::SB_READY] = 1'b1; // [R13]
                     sr_next[fpes_pkg::SB_VOLT_ERR] |= !high_programming_voltage; // [R13]
                     sr_next[fpes_pkg::SB_LOCK_ERR] |= block_locked; // [R13]
                  end else begin
                     st_next = fpes_pkg::FPES_FP_STREAM;
                     sr_next[fpes_pkg::SB_READY] = 1'b0; // [R13]
                     sr_next[fpes_pkg::SB_BUF_READY] = 1'b0; // [R14]
                     fcnt_next = '0;
                  end
               end
               fpes_pkg::FPES_FP_STREAM: begin
                  if (!same_blk && wr.data == fpes_pkg::FACT_EXIT_DATA) begin
                     exiting_next = 1'b1; // [R17]
                     sr_next[fpes_pkg::SB_READY] = 1'b0; // [R18]
                     if (!t_run) begin
                        t_load = 1'b1;
                        t_cycles = TW'(PROG_CYCLES);
                     end
                  end else if (!sr_reg[fpes_pkg::SB_BUF_READY] && !exiting_reg) begin
                     if (fcnt_reg == 10'(fpes_pkg::BUF_WORDS - 1)) begin
                        fcnt_next = '0;
                        sr_next[fpes_pkg::SB_BUF_READY] = 1'b1; // [R14] [R16]
                        t_load = 1'b1;
                        t_cycles = TW'(PROG_CYCLES * fpes_pkg::BUF_WORDS);
                     end else begin
                        fcnt_next = fcnt_reg + 1'b1;
                     end
                  end
               end
               fpes_pkg::FPES_ER_CONFIRM: begin
                  stat_mode_next = 1'b1;
                  if (code != fpes_pkg::CMD_CONFIRM || !same_blk) begin
                     st_next = fpes_pkg::FPES_IDLE;
                     sr_next[fpes_pkg::SB_ERASE_ERR] = 1'b1; // [R20]
                     sr_next[fpes_pkg::SB_PROG_ERR] = 1'b1; // [R20]
                  end else if (!high_programming_voltage) begin
                     st_next = fpes_pkg::FPES_IDLE;
                     sr_next[fpes_pkg::SB_VOLT_ERR] = 1'b1; // [R21]
                  end else if (block_locked) begin
                     st_next = fpes_pkg::FPES_IDLE;
                     sr_next[fpes_pkg::SB_LOCK_ERR] = 1'b1; // [R21]
                  end else begin
                     st_next = fpes_pkg::FPES_BUSY;
                     is_erase_next = 1'b1;
                     sr_next[fpes_pkg::SB_READY] = 1'b0;
                     t_load = 1'b1;
                     t_cycles = TW'(ERASE_CYCLES);
                  end
               end
               fpes_pkg::FPES_BUSY: begin
                  if (code == fpes_pkg::CMD_SUSPEND && !is_erase_reg && same_blk) begin
                     st_next = fpes_pkg::FPES_SUSPENDING; // [R2]
                     stat_mode_next = 1'b1;
                  end
               end
               fpes_pkg::FPES_SUSPENDED: begin
                  if (code == fpes_pkg::CMD_CONFIRM && same_blk) begin
                     st_next = fpes_pkg::FPES_BUSY; // [R4]
                     sr_next[fpes_pkg::SB_SUSP] = 1'b0; // [R4]
                     sr_next[fpes_pkg::SB_READY] = 1'b0; // [R4]
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Suspend uses a short separate wait so the frozen program time is not lost
   logic [15:0] susp_cnt_reg, susp_cnt_next;
   logic susp_done;
   always_comb begin
      susp_cnt_next = susp_cnt_reg;
      if (st_reg != fpes_pkg::FPES_SUSPENDING) begin
         susp_cnt_next = 16'(SUSP_CYCLES);
      end else if (susp_cnt_reg != '0) begin
         susp_cnt_next = susp_cnt_reg - 1'b1;
      end
   end
   assign susp_done = (st_reg == fpes_pkg::FPES_SUSPENDING) && (susp_cnt_reg == 16'h0001);

   fpes_pkg::fpes_state_t st_final;
   logic [7:0] sr_final;
   always_comb begin
      st_final = st_next;
      sr_final = sr_next;
      if (st_reg == fpes_pkg::FPES_SUSPENDING) begin
         if (t_done) begin
            // Program finished before suspend took hold
            st_final = fpes_pkg::FPES_IDLE;
            sr_final[fpes_pkg::SB_READY] = 1'b1; // [R2]
            sr_final[fpes_pkg::SB_SUSP] = 1'b0; // [R2]
            if (op_fail) sr_final[fpes_pkg::SB_PROG_ERR] = 1'b1;
         end else if (susp_done) begin
            st_final = fpes_pkg::FPES_SUSPENDED;
            sr_final[fpes_pkg::SB_SUSP] = 1'b1; // [R2]
            sr_final[fpes_pkg::SB_READY] = 1'b1; // [R2]
         end
      end
   end

   always_comb begin
      rd_addr_next = rd_addr_reg;
      prdata_next = prdata_reg;
      if (cmd_wr) rd_addr_next = wr.addr;
      if (psel && !penable && !pwrite) begin
         if (paddr == fpes_pkg::A_READ) begin
            // Array data is the word address; status read mode overrides
            prdata_next = stat_mode_reg ? {24'h000000, sr_reg} : {8'h00, rd_addr_reg};
         end else if (paddr == fpes_pkg::A_STATUS) begin
            prdata_next = {24'h000000, sr_reg};
         end else if (paddr == fpes_pkg::A_STATE) begin
            prdata_next = {15'h0000, stat_mode_reg, fcnt_reg[7:0], 4'h0, st_reg};
         end else begin
            prdata_next = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= fpes_pkg::FPES_IDLE;
         sr_reg <= 8'h80;
         stat_mode_reg <= 1'b0;
         blk_reg <= 24'h000000;
         cnt_reg <= 9'h000;
         fcnt_reg <= 10'h000;
         is_erase_reg <= 1'b0;
         exiting_reg <= 1'b0;
         rd_addr_reg <= 24'h000000;
         prdata_reg <= 32'h00000000;
         susp_cnt_reg <= 16'h0000;
      end else begin
         st_reg <= st_final;
         sr_reg <= sr_final;
         stat_mode_reg <= stat_mode_next;
         blk_reg <= blk_next;
         cnt_reg <= cnt_next;
         fcnt_reg <= fcnt_next;
         is_erase_reg <= is_erase_next;
         exiting_reg <= exiting_next;
         rd_addr_reg <= rd_addr_next;
         prdata_reg <= prdata_next;
         susp_cnt_reg <= susp_cnt_next;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = 1'b0;
endmodule : fpes_seq
`default_nettype wire

/* File: fpes_seq_monitor.sv */
// Purpose: Checker for status and command-stream behaviour of fpes_seq
// Assumes: Flash bus writes arrive as APB CMD writes {word addr, data}
// Notes: Helper state shadows commands and status reads; it never predicts timing
`timescale 1ns/1ps
`default_nettype none
module fpes_seq_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic high_programming_voltage,
   input wire logic block_locked
);
   typedef struct packed {
      logic [7:0] lc;
      logic [7:0] seen;
      logic sq, lk, sm, ab, go;
      logic [1:0] bs;
      logic [6:0] bb;
      logic [8:0] bl;
   } fpes_mon_t;
   fpes_mon_t m_reg, m_next;
   logic wr, rd_st, rd_rd, cf, bad;
   logic [7:0] op;
   assign wr = psel && penable && pwrite && paddr == fpes_pkg::A_CMD;
   assign rd_st = psel && penable && !pwrite && paddr == fpes_pkg::A_STATUS;
   assign rd_rd = psel && penable && !pwrite && paddr == fpes_pkg::A_READ;
   assign op = pwdata[7:0];
   assign bad = pwdata[31:25] != m_reg.bb;
   assign cf = op == fpes_pkg::CMD_CONFIRM && !bad;
   always_comb begin
      m_next = m_reg;
      if (rd_st || rd_rd) m_next.go = 1'b0;
      if (rd_st) m_next.seen = m_reg.seen | (prdata[7:0] & 8'h3a);
      if (wr) begin
         m_next.lc = op;
         m_next.ab = 1'b0;
         m_next.go = 1'b0;
         if (op == fpes_pkg::CMD_STATUS || op == fpes_pkg::CMD_CONFIRM) m_next.sm = 1'b1;
         if (op == fpes_pkg::CMD_ARRAY) m_next.sm = 1'b0;
         if (m_reg.lc == fpes_pkg::CMD_ERASE) begin
            m_next.sq = m_reg.sq | (op != fpes_pkg::CMD_CONFIRM);
            m_next.lk = m_reg.lk | (op == fpes_pkg::CMD_CONFIRM && block_locked);
         end
         if (op == fpes_pkg::CMD_CLR_STATUS) begin
            m_next.seen = 8'h00;
            m_next.sq = 1'b0;
            m_next.lk = 1'b0;
         end
         case (m_reg.bs)
            2'd0: begin
               m_next.bs = {1'b0, op == fpes_pkg::CMD_BUF_PROG};
               m_next.bb = pwdata[31:25];
            end
            2'd1: begin
               m_next.bs = 2'd2;
               m_next.bl = pwdata[8:0];
            end
            2'd2: begin
               m_next.ab = bad;
               m_next.bl = m_reg.bl - 9'h1;
               if (bad) m_next.bs = 2'd0;
               else if (m_reg.bl == 9'h0) m_next.bs = 2'd3;
            end
            default: begin
               m_next.bs = 2'd0;
               m_next.ab = !cf;
               m_next.go = cf && high_programming_voltage && !block_locked;
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_sticky; rd_st |-> (prdata[7:0] & m_reg.seen) == m_reg.seen; endproperty
   a_sticky: assert property (p_sticky) else $error("error bit lost");
   property p_seq; rd_st && prdata[7] && m_reg.sq |-> prdata[5:4] == 2'b11; endproperty
   a_seq: assert property (p_seq) else $error("bad erase not flagged");
   property p_lock; rd_st && prdata[7] && m_reg.lk |-> prdata[1]; endproperty
   a_lock: assert property (p_lock) else $error("locked erase not flagged");
   property p_susp; rd_st && prdata[2] |-> prdata[7] && !prdata[0]; endproperty
   a_susp: assert property (p_susp) else $error("suspended but busy");
   property p_buf; rd_st && prdata[0] |-> !prdata[7] && !prdata[2]; endproperty
   a_buf: assert property (p_buf) else $error("buffer busy outside stream");
   property p_abort; rd_st && m_reg.ab |-> prdata[7]; endproperty
   a_abort: assert property (p_abort) else $error("aborted sequence ran");
   property p_go; rd_rd && m_reg.go |-> prdata[31:7] == 25'h0; endproperty
   a_go: assert property (p_go) else $error("confirm gave no busy status");
   property p_smode; rd_rd && m_reg.sm |-> prdata[31:8] == 24'h0; endproperty
   a_smode: assert property (p_smode) else $error("status mode left");
   c_susp: cover property (rd_st && prdata[2]);
   c_go: cover property (rd_rd && m_reg.go);
   c_buf: cover property (rd_st && prdata[0]);
endmodule : fpes_seq_monitor
bind fpes_seq fpes_seq_monitor u_mon (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .high_programming_voltage(high_programming_voltage), .block_locked(block_locked)
);
`default_nettype wire

/* File: fpes_host_model.sv */
// Purpose: Host-side flash bus master speaking APB to fpes_seq
// Assumes: One transfer at a time, launched just after a rising edge
// Notes: Waits on pready with no cycle count; the bench watchdog ends hangs
`timescale 1ns/1ps
`default_nettype none
module fpes_host_model (
   input wire logic clk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic cmd(input logic [15:0] a, input logic [15:0] d);
      logic [31:0] q;
      xfer(1'b1, fpes_pkg::A_CMD, {a, d}, q);
   endtask : cmd
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask : rd
endmodule : fpes_host_model
`default_nettype wire

/* File: fpes_seq_tb.sv */
// Purpose: Self-checking bench for fpes_seq
// Assumes: Short erase, program and suspend times set by parameters
// Notes: Status values are built from the documented bit positions
`timescale 1ns/1ps
`default_nettype none
module fpes_seq_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic hv = 1'b1;
   logic lk = 1'b0;
   logic fl = 1'b0;
   int fails = 0;
   int checked = 0;
   always #25 clk = ~clk;
   fpes_seq #(.ERASE_CYCLES(50), .PROG_CYCLES(16), .SUSP_CYCLES(5)) dut (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .high_programming_voltage(hv), .block_locked(lk), .op_fail(fl));
   fpes_host_model host (.clk(clk), .pready(pready), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   function automatic logic [15:0] ba(input logic [6:0] k);
      return {k, 9'h000};
   endfunction : ba
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic sr();
      host.rd(fpes_pkg::A_STATUS, q);
   endtask : sr
   task automatic poll(input int b, input logic v);
      int n = 0;
      sr();
      while (q[b] !== v && n < 5000) begin
         sr();
         n++;
      end
   endtask : poll
   task automatic load(input logic [6:0] k, input logic [15:0] cnt, input int n);
      host.cmd(ba(k), 16'h00e9);
      host.cmd(ba(k), cnt);
      for (int i = 0; i < n; i++) host.cmd(ba(k) + 16'(i), 16'h1234);
   endtask : load
   task automatic t_reset();
      sr();
      chk("status", 32'h80, q);
      host.rd(8'h0c, q);
      chk("unmapped", 32'h0, q);
      chk("slverr", 32'h0, {31'h0, pslverr});
      $display("test reset done");
   endtask : t_reset
   task automatic t_erase();
      logic [7:0] ex [5] = '{8'h80, 8'h82, 8'h88, 8'ha0, 8'hb0};
      for (int i = 0; i < 5; i++) begin
         lk <= (i == 1);
         hv <= (i != 2);
         fl <= (i == 3);
         host.cmd(ba(7'd1), 16'h0020);
         host.cmd(ba(7'd1), i == 4 ? 16'h00ff : 16'h00d0);
         poll(7, 1'b1);
         chk("erase status", {24'h0, ex[i]}, q);
         host.cmd(ba(7'd1), 16'h00ff);
         host.cmd(ba(7'd1), 16'h0070);
         sr();
         chk("kept status", {24'h0, ex[i]}, q);
         host.cmd(ba(7'd1), 16'h0050);
         sr();
         chk("cleared status", 32'h80, q);
      end
      $display("test erase done");
   endtask : t_erase
   task automatic t_buf();
      // Bits above the low nine of the count must be ignored
      load(7'd2, 16'hfe02, 3);
      host.cmd(ba(7'd2), 16'h00d0);
      host.rd(fpes_pkg::A_READ, q);
      chk("read after confirm", 32'h0, q);
      poll(7, 1'b1);
      host.rd(fpes_pkg::A_READ, q);
      chk("status mode read", 32'h80, q);
      for (int i = 0; i < 3; i++) begin
         load(7'd2, 16'h0001, 1);
         host.cmd(ba(i == 0 ? 7'd3 : 7'd2), 16'h1234);
         host.cmd(ba(i == 2 ? 7'd3 : 7'd2), i == 1 ? 16'h00ff : 16'h00d0);
         sr();
         chk("abort ready", 32'h80, q & 32'h80);
         host.cmd(ba(7'd2), 16'h0050);
      end
      $display("test buffered done");
   endtask : t_buf
   task automatic t_susp();
      load(7'd4, 16'h0003, 4);
      host.cmd(ba(7'd4), 16'h00d0);
      host.cmd(ba(7'd4), 16'h00b0);
      host.cmd(ba(7'd4), 16'h0070);
      poll(7, 1'b1);
      chk("suspended", 32'h84, q);
      host.cmd(ba(7'd5), 16'h00ff);
      host.rd(fpes_pkg::A_READ, q);
      chk("array read", {8'h0, ba(7'd5), 8'h0}, q);
      host.cmd(ba(7'd4), 16'h0070);
      host.rd(fpes_pkg::A_READ, q);
      chk("back to status", 32'h84, q);
      host.cmd(ba(7'd4), 16'h00d0);
      sr();
      chk("resumed", 32'h0, q);
      poll(7, 1'b1);
      chk("resume done", 32'h80, q);
      $display("test suspend done");
   endtask : t_susp
   task automatic t_fact();
      logic [7:0] fx [3] = '{8'h88, 8'h82, 8'h00};
      for (int i = 0; i < 3; i++) begin
         hv <= (i != 0);
         lk <= (i == 1);
         host.cmd(ba(7'd6), 16'h0080);
         host.cmd(ba(7'd6), 16'h00d0);
         poll(7, fx[i][7]);
         chk("factory setup", {24'h0, fx[i]}, q);
         if (i < 2) host.cmd(ba(7'd6), 16'h0050);
      end
      for (int i = 0; i < 512; i++) host.cmd(ba(7'd6), 16'h5a5a);
      sr();
      chk("buffer busy", 32'h01, q & 32'h81);
      poll(0, 1'b0);
      chk("buffer done", 32'h0, q);
      host.cmd(ba(7'd7), fpes_pkg::FACT_EXIT_DATA);
      poll(7, 1'b1);
      chk("exit status", 32'h80, q);
      $display("test factory done");
   endtask : t_fact
   task automatic report_and_stop();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #2000000;
      fails++;
      $display("ERROR watchdog expected finish seen timeout");
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_erase();
      t_buf();
      t_susp();
      t_fact();
      report_and_stop();
   end
endmodule : fpes_seq_tb
`default_nettype wire
